// ### usbi_pkg.sv
// What this block does
// - endpoint done flag on ack, stall, timeout, in or out exception
// - nak also sets the endpoint done flag when its nak enable is set
// - enable bits 7..0 enable endpoint 7..0 done interrupts, one means enabled
// - device address resets to zero
// - only traffic to the held address is answered, the rest ignored
// - address is seven write-only bits 6..0, bits 15..7 reserved
// - writing one to a status flag clears it, zero leaves it
// - status reachable by on-chip processor and parallel host port
// - status bit 15 set on both edges of vbus valid, first engine only
// - status bit 14 set on both edges of otg id, first engine only
// - vbus and id flags exist only in the first engine
// - status bit 9 set on sof or eop keep-alive received
// - status bit 8 set on usb bus reset detected
// - address register exists per engine at its own offset
// - status bits 7..0 record endpoint done interrupts
// - enable bits 15, 14, 9, 8 for vbus, id, sof/eop, bus reset
`default_nettype none
package usbi_pkg;
	localparam int          ENG_COUNT   = 2;
	localparam int          EP_COUNT    = 8;
	localparam int          ADDR_W      = 7;
	localparam logic [15:0] OFS_IE1     = 16'hc08c;
	localparam logic [15:0] OFS_ADDR1   = 16'hc08e;
	localparam logic [15:0] OFS_STAT1   = 16'hc090;
	localparam logic [15:0] OFS_IE2     = 16'hc0ac;
	localparam logic [15:0] OFS_ADDR2   = 16'hc0ae;
	localparam logic [15:0] OFS_STAT2   = 16'hc0b0;
	localparam int          BIT_VBUS    = 15;
	localparam int          BIT_ID      = 14;
	localparam int          BIT_TMO_EN  = 11;
	localparam int          BIT_SOF     = 9;
	localparam int          BIT_BRST    = 8;
	localparam logic [15:0] STAT_MASK1  = 16'hc3ff;
	localparam logic [15:0] STAT_MASK2  = 16'h03ff;
	localparam logic [15:0] IE_MASK1    = 16'hcbff;
	localparam logic [15:0] IE_MASK2    = 16'h0bff;
	localparam logic [15:0] IE_RESET    = 16'h0000;
	localparam logic [15:0] STAT_RESET  = 16'h0000;
	localparam logic [6:0]  ADDR_RESET  = 7'h00;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} usbi_bus_s;

	typedef struct packed {
		logic [7:0] ack;
		logic [7:0] stall;
		logic [7:0] timeout;
		logic [7:0] in_err;
		logic [7:0] out_err;
		logic [7:0] nak;
	} usbi_ep_evt_s;
endpackage
`default_nettype wire

// ### usbi_irq_addr.sv
`timescale 1ns/1ps
`default_nettype none
module usbi_irq_addr (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire usbi_pkg::usbi_bus_s     cpu_bus,
	output logic [15:0]                  cpu_rdata,
	input  wire usbi_pkg::usbi_bus_s     hpi_bus,
	output logic [15:0]                  hpi_rdata,
	input  wire usbi_pkg::usbi_ep_evt_s  ep_evt_0,
	input  wire usbi_pkg::usbi_ep_evt_s  ep_evt_1,
	input  wire logic [7:0]              nak_int_en_0,
	input  wire logic [7:0]              nak_int_en_1,
	input  wire logic [1:0]              sof_eop_rx,
	input  wire logic [1:0]              bus_reset_det,
	input  wire logic                    vbus_valid,
	input  wire logic                    otg_id,
	input  wire logic [1:0]              tok_valid,
	input  wire logic [6:0]              tok_addr_0,
	input  wire logic [6:0]              tok_addr_1,
	output logic [1:0]                   addr_match,
	output logic [6:0]                   dev_address_0,
	output logic [6:0]                   dev_address_1,
	output logic [1:0]                   irq
);
	// write strobe for one register
	function automatic logic wr_hit(input usbi_pkg::usbi_bus_s b, input logic [15:0] ofs);
		wr_hit = b.wr && (b.addr == ofs);
	endfunction

	// read mux; address registers are write-only and read as zero
	function automatic logic [15:0] rd_word(input logic [15:0] a, input logic [15:0] ie0,
			input logic [15:0] st0, input logic [15:0] ie1, input logic [15:0] st1);
		logic [15:0] d;
		d = 16'h0000;
		if (a == usbi_pkg::OFS_IE1) d = ie0;
		if (a == usbi_pkg::OFS_STAT1) d = st0;
		if (a == usbi_pkg::OFS_IE2) d = ie1;
		if (a == usbi_pkg::OFS_STAT2) d = st1;
		rd_word = d;
	endfunction

	// endpoint transaction done: terminal handshakes, plus nak when enabled
	function automatic logic [7:0] ep_done(input usbi_pkg::usbi_ep_evt_s e, input logic [7:0] nak_en);
		ep_done = e.ack | e.stall | e.timeout | e.in_err | e.out_err
			| (e.nak & nak_en);
	endfunction

	logic [15:0] ie_reg   [2];
	logic [15:0] st_reg   [2];
	logic [6:0]  addr_reg [2];
	// one flop per engine, each written by its own engine's process only
	logic        match_reg [2];
	logic        irq_reg   [2];
	logic [15:0] cpu_rdata_reg;
	logic [15:0] hpi_rdata_reg;
	logic        vbus_prev_reg;
	logic        id_prev_reg;
	logic        primed_reg;

	// otg pin edges; primed blocks a false edge on the first cycle after reset
	wire vbus_edge = primed_reg & (vbus_valid ^ vbus_prev_reg);
	wire id_edge   = primed_reg & (otg_id ^ id_prev_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vbus_prev_reg <= 1'b0;
			id_prev_reg   <= 1'b0;
			primed_reg    <= 1'b0;
		end else begin
			vbus_prev_reg <= vbus_valid;
			id_prev_reg   <= otg_id;
			primed_reg    <= 1'b1;
		end
	end

	wire [7:0] done_0   = ep_done(ep_evt_0, nak_int_en_0);
	wire [7:0] done_1   = ep_done(ep_evt_1, nak_int_en_1);
	wire [6:0] tok_a [2];
	assign tok_a[0] = tok_addr_0;
	assign tok_a[1] = tok_addr_1;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : eng
			localparam logic [15:0] OFS_IE   = (g == 0) ? usbi_pkg::OFS_IE1 : usbi_pkg::OFS_IE2;
			localparam logic [15:0] OFS_ADDR = (g == 0) ? usbi_pkg::OFS_ADDR1 : usbi_pkg::OFS_ADDR2;
			localparam logic [15:0] OFS_STAT = (g == 0) ? usbi_pkg::OFS_STAT1 : usbi_pkg::OFS_STAT2;
			// second engine has no otg flags or enables
			localparam logic [15:0] ST_MASK  = (g == 0) ? usbi_pkg::STAT_MASK1 : usbi_pkg::STAT_MASK2;
			localparam logic [15:0] IE_MASK  = (g == 0) ? usbi_pkg::IE_MASK1 : usbi_pkg::IE_MASK2;

			// register decode; cpu wins when both ports write the same enable
			wire cpu_ie  = wr_hit(cpu_bus, OFS_IE);
			wire hpi_ie  = wr_hit(hpi_bus, OFS_IE);
			wire cpu_ad  = wr_hit(cpu_bus, OFS_ADDR);
			wire hpi_ad  = wr_hit(hpi_bus, OFS_ADDR);
			wire cpu_st  = wr_hit(cpu_bus, OFS_STAT);
			wire hpi_st  = wr_hit(hpi_bus, OFS_STAT);

			// reserved bits are masked rather than trusting software to write zero
			wire [15:0] ie_next = cpu_ie ? (cpu_bus.wdata & IE_MASK)
				: hpi_ie ? (hpi_bus.wdata & IE_MASK) : ie_reg[g];
			wire [6:0] addr_next = cpu_ad ? cpu_bus.wdata[6:0]
				: hpi_ad ? hpi_bus.wdata[6:0] : addr_reg[g];

			// event set vector in status bit order
			wire [7:0] done = (g == 0) ? done_0 : done_1;
			wire [15:0] st_set = {vbus_edge, id_edge, 4'h0, sof_eop_rx[g], bus_reset_det[g], done}
				& ST_MASK;
			wire [15:0] st_clr = (cpu_st ? cpu_bus.wdata : 16'h0000)
				| (hpi_st ? hpi_bus.wdata : 16'h0000);
			// set wins over a same-cycle clear so no event is lost
			wire [15:0] st_next = ((st_reg[g] & ~st_clr) | st_set) & ST_MASK;

			wire irq_next   = |(st_reg[g] & ie_reg[g]);
			wire match_next = tok_valid[g] && (tok_a[g] == addr_reg[g]);

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					ie_reg[g]    <= usbi_pkg::IE_RESET;
					st_reg[g]    <= usbi_pkg::STAT_RESET;
					addr_reg[g]  <= usbi_pkg::ADDR_RESET;
					irq_reg[g]   <= 1'b0;
					match_reg[g] <= 1'b0;
				end else begin
					ie_reg[g]    <= ie_next;
					st_reg[g]    <= st_next;
					addr_reg[g]  <= addr_next;
					irq_reg[g]   <= irq_next;
					match_reg[g] <= match_next;
				end
			end
		end
	endgenerate

	// read data valid the cycle after rd, zero otherwise
	wire [15:0] cpu_rd_next = cpu_bus.rd ? rd_word(cpu_bus.addr, ie_reg[0], st_reg[0], ie_reg[1], st_reg[1])
		: 16'h0000;
	wire [15:0] hpi_rd_next = hpi_bus.rd ? rd_word(hpi_bus.addr, ie_reg[0], st_reg[0], ie_reg[1], st_reg[1])
		: 16'h0000;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rdata_reg <= 16'h0000;
			hpi_rdata_reg <= 16'h0000;
		end else begin
			cpu_rdata_reg <= cpu_rd_next;
			hpi_rdata_reg <= hpi_rd_next;
		end
	end

	assign cpu_rdata     = cpu_rdata_reg;
	assign hpi_rdata     = hpi_rdata_reg;
	assign addr_match    = {match_reg[1], match_reg[0]};
	assign irq           = {irq_reg[1], irq_reg[0]};
	assign dev_address_0 = addr_reg[0];
	assign dev_address_1 = addr_reg[1];
endmodule
`default_nettype wire

// ### usbi_irq_addr_props.sv
`timescale 1ns/1ps
`default_nettype none
module usbi_irq_addr_props (
	input wire logic                clk,
	input wire logic                reset_n,
	input wire usbi_pkg::usbi_bus_s cpu_bus,
	input wire usbi_pkg::usbi_bus_s hpi_bus,
	input wire logic [15:0]         cpu_rdata,
	input wire logic [1:0]          tok_valid,
	input wire logic [6:0]          tok_addr_0,
	input wire logic [1:0]          addr_match,
	input wire logic [6:0]          dev_address_0
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// a token for the held address, and a read of one offset
	sequence s_hit; tok_valid[0] && tok_addr_0 == dev_address_0; endsequence
	sequence s_rd(a); cpu_bus.rd && cpu_bus.addr == a; endsequence
	// the filter, the write-only address register and idle or unmapped reads
	a_match_hit: assert property (s_hit |=> addr_match[0]) else $error("no match pulse");
	a_ignore_other: assert property (tok_valid[0] && tok_addr_0 != dev_address_0 |=> !addr_match[0])
		else $error("match on foreign address");
	a_match_idle: assert property (!tok_valid[0] |=> !addr_match[0]) else $error("match without token");
	a_addr_load: assert property (cpu_bus.wr && cpu_bus.addr == 16'hc08e
		|=> dev_address_0 == $past(cpu_bus.wdata[6:0])) else $error("address not loaded");
	a_addr_hold: assert property (!cpu_bus.wr && !hpi_bus.wr |=> $stable(dev_address_0))
		else $error("address changed without write");
	a_addr_wo: assert property (s_rd(16'hc08e) |=> cpu_rdata == 16'h0000) else $error("address readable");
	a_unmapped: assert property (s_rd(16'hc092) |=> cpu_rdata == 16'h0000) else $error("unmapped read");
	a_rd_idle: assert property (!cpu_bus.rd |=> cpu_rdata == 16'h0000) else $error("stray read data");
endmodule
bind usbi_irq_addr usbi_irq_addr_props props_i (.clk(clk), .reset_n(reset_n), .cpu_bus(cpu_bus), .hpi_bus(hpi_bus),
	.cpu_rdata(cpu_rdata), .tok_valid(tok_valid), .tok_addr_0(tok_addr_0), .addr_match(addr_match),
	.dev_address_0(dev_address_0));
`default_nettype wire

// ### usbi_host_m.sv
`timescale 1ns/1ps
`default_nettype none
// usb host side: sends token addresses to either engine
module usbi_host_m (
	input  wire logic  clk,
	output logic [1:0] tok_valid,
	output logic [6:0] tok_addr_0,
	output logic [6:0] tok_addr_1
);
	initial tok_valid = '0;
	initial {tok_addr_1, tok_addr_0} = 14'h3fff;
	// released lines show the inverse so a stale address cannot match
	task automatic send(input int e, input logic [6:0] a);
		@(posedge clk);
		tok_valid[e] <= 1'b1;
		{tok_addr_1, tok_addr_0} <= {a, a};
		@(posedge clk);
		tok_valid <= '0;
		{tok_addr_1, tok_addr_0} <= {~a, ~a};
	endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  clk = 1'b0;
	logic                  reset_n, vbus, oid;
	logic [1:0]            sof, brst, tok_valid, addr_match, irq;
	logic [6:0]            ta0, ta1, da0, da1;
	logic [7:0]            nak0;
	logic [15:0]           cpu_rdata, hpi_rdata;
	usbi_pkg::usbi_bus_s   cb, hb;
	usbi_pkg::usbi_ep_evt_s ev0;
	int                    errors = 0, n_checks = 0;
	always #50 clk = ~clk;
	usbi_host_m usbi_host_m_i (.clk(clk), .tok_valid(tok_valid), .tok_addr_0(ta0), .tok_addr_1(ta1));
	usbi_irq_addr usbi_irq_addr_i (.clk(clk), .reset_n(reset_n), .cpu_bus(cb), .cpu_rdata(cpu_rdata), .hpi_bus(hb),
		.hpi_rdata(hpi_rdata), .ep_evt_0(ev0), .ep_evt_1('0), .nak_int_en_0(nak0), .nak_int_en_1(8'h00),
		.sof_eop_rx(sof), .bus_reset_det(brst), .vbus_valid(vbus), .otg_id(oid), .tok_valid(tok_valid),
		.tok_addr_0(ta0), .tok_addr_1(ta1), .addr_match(addr_match), .dev_address_0(da0),
		.dev_address_1(da1), .irq(irq));
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	// one bus cycle, held from one edge to the sampling edge
	task automatic acc(input logic h, w, input logic [15:0] a, d);
		@(posedge clk);
		if (h) hb <= '{w, !w, a, d};
		else cb <= '{w, !w, a, d};
		@(posedge clk);
		{cb, hb} <= '0;
	endtask
	task automatic rd(input logic h, input logic [15:0] a, e);
		acc(h, 1'b0, a, 16'h0000);
		#1 chk("rdata", h ? hpi_rdata : cpu_rdata, e);
	endtask
	task automatic pulse(input usbi_pkg::usbi_ep_evt_s e);
		@(posedge clk);
		ev0 <= e;
		@(posedge clk);
		ev0 <= '0;
	endtask
	// watchdog well beyond the roughly 80 cycles the run needs
	initial begin
		#200000;
		errors++;
		complete_run;
	end
	initial begin
		{cb, hb, ev0, sof, brst, vbus, oid, reset_n} = '0;
		nak0 = 8'h40;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		chk("addr0", {9'h000, da0}, 16'h0000);
		rd(0, 16'hc08c, 16'h0000);
		rd(1, 16'hc0b0, 16'h0000);
		acc(0, 1, 16'hc08c, 16'hcbff);
		acc(1, 1, 16'hc0ac, 16'h0bff);
		rd(0, 16'hc08c, 16'hcbff);
		rd(1, 16'hc0ac, 16'h0bff);
		// ack, stall, timeout, in and out errors on ep0..4, masked nak on ep5, enabled nak on ep6
		for (int f = 0; f < 6; f++) pulse(48'h1 << (8 * (5 - f) + f));
		pulse(48'h40);
		rd(0, 16'hc090, 16'h005f);
		chk("irq", {14'h0000, irq}, 16'h0001);
		acc(1, 1, 16'hc090, 16'h0001);
		rd(0, 16'hc090, 16'h005e);
		acc(0, 1, 16'hc090, 16'h005e);
		@(posedge clk);
		#1 chk("irq", {14'h0000, irq}, 16'h0000);
		// both pin edges, sof/eop and bus reset on both engines
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			{vbus, oid, sof, brst} <= {~vbus, ~oid, 4'hf};
			@(posedge clk);
			{sof, brst} <= '0;
			rd(0, 16'hc090, 16'hc300);
			rd(1, 16'hc0b0, 16'h0300);
			acc(0, 1, 16'hc090, 16'hc300);
			acc(0, 1, 16'hc0b0, 16'h0300);
		end
		acc(0, 1, 16'hc08e, 16'h0055);
		acc(1, 1, 16'hc0ae, 16'h0033);
		rd(0, 16'hc08e, 16'h0000);
		rd(0, 16'hc092, 16'h0000);
		chk("addr0", {9'h000, da0}, 16'h0055);
		chk("addr1", {9'h000, da1}, 16'h0033);
		usbi_host_m_i.send(0, 7'h55);
		#1 chk("match", {14'h0000, addr_match}, 16'h0001);
		usbi_host_m_i.send(1, 7'h55);
		#1 chk("match", {14'h0000, addr_match}, 16'h0000);
		usbi_host_m_i.send(1, 7'h33);
		#1 chk("match", {14'h0000, addr_match}, 16'h0002);
		complete_run;
	end
endmodule
`default_nettype wire
